// >>> logic/bsc_pkg.sv
/*
  constants for the buck set-point and switching clock controller:
  clock rate, pll timing, step intervals, range straps and reset values.
  assumes a single 100 mhz clock and that software fields arrive as plain ports.
*/
// What this block does
// R1 - default pll multiplier is ninety-six
// R2 - select codes map 84..105 in threes
// R3 - pll off when all bucks off/pfm
// R4 - clock ready within 700/600 ns
// R5 - force-on bit keeps pll running, resets zero
// R6 - multiplier select resets to code 100
// R7 - low range code zero is 0.600 V
// R8 - high range starts 1.100 V, tops 1.850 V
// R9 - software keeps buck one range bit clear
// R10 - range bits follow strap after startup
// R11 - range bits rewritable, apply to all set points
// R12 - software changes range bits with care
// R13 - three set points, controlled transitions only
// R14 - dvs pin picks normal or scaled code
// R15 - both sleep pins high pick sleep code
// R16 - normal code writes step at dvs rate
// R17 - sleep entry and exit step at dvs rate
// R18 - step interval select 2/4/8/16 us, default 01
// R19 - bucks three and four step every 4 us
// R20 - one code per interval, stop at target
package bsc_pkg;
  localparam int CLK_PERIOD_NS = 10; // mclk period
  localparam int NUM_BUCKS = 4; // bucks handled
  localparam int CODE_W = 5; // set-point code width
  localparam int CNT_W = 11; // step interval counter width
  // pll start-up longest times, rounded down to cycles
  localparam int PLL_COLD_NS = 700;
  localparam int PLL_WARM_NS = 600;
  localparam logic [6:0] PLL_COLD_CYC = 7'(PLL_COLD_NS / CLK_PERIOD_NS);
  localparam logic [6:0] PLL_WARM_CYC = 7'(PLL_WARM_NS / CLK_PERIOD_NS);
  // multiplier: factor = base + step * code
  localparam logic [6:0] PLL_MULT_BASE = 7'h54; // 84
  localparam logic [6:0] PLL_MULT_STEP = 7'h03; // 3
  localparam logic [2:0] PLL_MULT_SEL_RST = 3'h4; // code 100 gives 96
  localparam logic PLL_FORCE_ON_RST = 1'b0;
  // step intervals in ns, indexed by step_interval_sel
  localparam int STEP_2US_NS = 2000;
  localparam int STEP_4US_NS = 4000;
  localparam int STEP_8US_NS = 8000;
  localparam int STEP_16US_NS = 16000;
  localparam logic [1:0] STEP_SEL_RST = 2'h1; // 4 us default
  localparam logic [CNT_W-1:0] STEP_2US_CYC = CNT_W'(STEP_2US_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STEP_4US_CYC = CNT_W'(STEP_4US_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STEP_8US_CYC = CNT_W'(STEP_8US_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STEP_16US_CYC = CNT_W'(STEP_16US_NS / CLK_PERIOD_NS);
  // range bits after startup: buck four high, buck one low
  localparam logic [3:0] RANGE_RST = 4'h0;
  localparam logic [3:0] RANGE_STRAP_OPEN = 4'h8;
  localparam logic [3:0] RANGE_STRAP_GND = 4'he;
  localparam logic [CODE_W-1:0] CODE_RST = 5'h00;
endpackage

// >>> logic/bsc_step_if.sv
/*
  carrier between the controller and one set-point stepper.
  assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface bsc_step_if;
  import bsc_pkg::*;
  logic [CODE_W-1:0] target; // selected set point
  logic [CNT_W-1:0] interval; // cycles per step
  logic [CODE_W-1:0] code; // code applied to regulator
  logic busy; // code not yet at target
  modport ctrl (output target, output interval, input code, input busy);
  modport stepper (input target, input interval, output code, output busy);
endinterface // bsc_step_if

// >>> logic/bsc_stepper.sv
/*
  one set-point stepper: walks the applied code one step per interval
  toward the target. assumes interval is at least one cycle.
*/
`timescale 1ns/1ps
module bsc_stepper
  import bsc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  bsc_step_if.stepper sif
);
  logic [CODE_W-1:0] code_reg, code_next; // applied code
  logic [CNT_W-1:0] cnt_reg, cnt_next; // cycles left in interval
  logic busy_reg, busy_next;

  // next step: wait a full interval, then move one code
  always_comb
  begin
    code_next = code_reg;
    cnt_next = cnt_reg;
    if (code_reg == sif.target)
    begin
      cnt_next = sif.interval - 1'b1; // idle: rearm interval [R20]
    end
    else if (cnt_reg == '0)
    begin
      // one code toward target [R20] [R13]
      code_next = (sif.target > code_reg) ? code_reg + 1'b1 : code_reg - 1'b1;
      cnt_next = sif.interval - 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg - 1'b1; // counting down
    end
    busy_next = (code_next != sif.target);
  end

  // registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      code_reg <= CODE_RST;
      cnt_reg <= STEP_4US_CYC;
      busy_reg <= 1'b0;
    end
    else
    begin
      code_reg <= code_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign sif.code = code_reg;
  assign sif.busy = busy_reg;

  a_step_one_code: assert property (@(posedge mclk) disable iff (reset) // [R20]
    (code_reg != $past(code_reg)) |->
      ((code_reg == $past(code_reg) + 1'b1) || (code_reg == $past(code_reg) - 1'b1)))
    else $error("applied code moved by more than one");
  a_step_no_overshoot: assert property (@(posedge mclk) disable iff (reset) // [R20]
    (code_reg == sif.target && $stable(sif.target)) |=> $stable(code_reg))
    else $error("code left a stable target");
  a_step_spacing: assert property (@(posedge mclk) disable iff (reset) // [R13]
    (code_reg != $past(code_reg) && sif.interval > 11'd2) |=> $stable(code_reg))
    else $error("two steps in adjacent cycles");
  c_step_up: cover property (@(posedge mclk) disable iff (reset)
    code_reg == $past(code_reg) + 1'b1);
  c_step_down: cover property (@(posedge mclk) disable iff (reset)
    code_reg == $past(code_reg) - 1'b1);
endmodule // bsc_stepper

// >>> logic/bsc_ctrl.sv
/*
  buck set-point and switching clock controller: pll run and multiplier,
  range bits, set-point selection and stepping for four bucks.
  assumes pins and software fields are synchronous to mclk.
*/
`timescale 1ns/1ps
module bsc_ctrl
  import bsc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic global_rst_n,
  input wire logic pll_wr,
  input wire logic pll_force_on_wdata,
  input wire logic [2:0] pll_mult_sel_wdata,
  input wire logic [3:0] range_wr,
  input wire logic [3:0] range_wdata,
  input wire logic powerup_strap2_grounded,
  input wire logic [3:0][4:0] normal_setpoint_code,
  input wire logic [1:0][4:0] scaled_setpoint_code,
  input wire logic [3:0][4:0] sleep_setpoint_code,
  input wire logic [1:0][1:0] step_interval_sel,
  input wire logic [1:0] scaling_select_pin,
  input wire logic sleep_request_primary,
  input wire logic sleep_request_secondary,
  input wire logic [3:0] buck_on,
  input wire logic [3:0] buck_pfm,
  input wire logic pll_needed_ext,
  output logic pll_force_on,
  output logic [2:0] pll_mult_sel,
  output logic [6:0] pll_mult_factor,
  output logic pll_run,
  output logic pll_clk_ok,
  output logic [3:0] range_high_sel,
  output logic [3:0][4:0] applied_code,
  output logic [3:0] step_busy
);
  // pll control state
  logic force_reg, force_next; // forced-on bit
  logic [2:0] mult_sel_reg, mult_sel_next; // multiplier select
  logic [6:0] factor_reg, factor_next; // decoded factor
  logic run_reg, run_next; // pll enable
  logic ok_reg, ok_next; // clock available to switchers
  logic [6:0] start_reg, start_next; // start-up countdown
  logic [3:0] pfm_prev_reg; // pfm state last cycle
  logic need_pwm; // some buck switching in pwm, or pll_needed_ext set
  logic pfm_exit; // a running buck left pfm
  // range state
  logic [3:0] range_reg, range_next; // range bits
  logic init_reg, init_next; // startup load pending
  logic sleep_cond; // both sleep pins high
  logic [3:0][4:0] code_q; // stepper outputs
  logic [3:0] busy_q;
  logic [3:0][4:0] target; // selected set points
  logic [3:0][CNT_W-1:0] interval; // per-buck step interval

  bsc_step_if sif [NUM_BUCKS] ();

  // the per-buck ports and the dvs pair are laid out for four bucks only
  if (NUM_BUCKS != 4)
  begin : g_bad_count
    $error("controller built for four bucks only");
  end

  // pll next-state
  always_comb
  begin
    force_next = force_reg;
    mult_sel_next = mult_sel_reg;
    if (!global_rst_n)
    begin
      force_next = PLL_FORCE_ON_RST; // cleared by global reset [R5]
    end
    else if (pll_wr)
    begin
      force_next = pll_force_on_wdata; // [R5]
      mult_sel_next = pll_mult_sel_wdata; // [R6]
    end
    factor_next = PLL_MULT_BASE + 7'(PLL_MULT_STEP * mult_sel_next); // [R2] [R1]
    need_pwm = |(buck_on & ~buck_pfm) | pll_needed_ext;
    pfm_exit = |(buck_on & pfm_prev_reg & ~buck_pfm);
    run_next = force_next | need_pwm; // auto-off when idle [R3] [R5]
    ok_next = ok_reg;
    start_next = start_reg;
    if (!run_next)
    begin
      ok_next = 1'b0; // pll stopped
      start_next = '0;
    end
    else if (!run_reg)
    begin
      // fresh start: warm time for pfm exit, else cold time [R4]
      start_next = (pfm_exit ? PLL_WARM_CYC : PLL_COLD_CYC) - 7'h01;
      ok_next = 1'b0;
    end
    else if (!ok_reg)
    begin
      if (start_reg == '0)
      begin
        ok_next = 1'b1; // clock ready [R4]
      end
      else
      begin
        start_next = start_reg - 7'h01;
      end
    end
  end

  // pll registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      force_reg <= PLL_FORCE_ON_RST;
      mult_sel_reg <= PLL_MULT_SEL_RST;
      factor_reg <= PLL_MULT_BASE + 7'(PLL_MULT_STEP * PLL_MULT_SEL_RST);
      run_reg <= 1'b0;
      ok_reg <= 1'b0;
      start_reg <= '0;
      pfm_prev_reg <= 4'h0;
    end
    else
    begin
      force_reg <= force_next;
      mult_sel_reg <= mult_sel_next;
      factor_reg <= factor_next;
      run_reg <= run_next;
      ok_reg <= ok_next;
      start_reg <= start_next;
      pfm_prev_reg <= buck_pfm;
    end
  end

  // range bits next-state
  always_comb
  begin
    range_next = range_reg;
    init_next = 1'b0;
    if (init_reg)
    begin
      // strap decides startup range [R10]
      range_next = powerup_strap2_grounded ? RANGE_STRAP_GND : RANGE_STRAP_OPEN;
    end
    else
    begin
      for (int i = 0; i < NUM_BUCKS; i++)
      begin
        if (range_wr[i])
        begin
          range_next[i] = range_wdata[i]; // software rewrite [R11]
        end
      end
    end
  end

  // range registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      range_reg <= RANGE_RST;
      init_reg <= 1'b1;
    end
    else
    begin
      range_reg <= range_next;
      init_reg <= init_next;
    end
  end

  assign sleep_cond = sleep_request_primary & sleep_request_secondary; // [R15]

  // set-point selection and step interval per buck
  always_comb
  begin
    for (int i = 0; i < NUM_BUCKS; i++)
    begin
      target[i] = sleep_cond ? sleep_setpoint_code[i] : normal_setpoint_code[i]; // [R17]
      interval[i] = STEP_4US_CYC; // fixed rate for three and four [R19]
    end
    for (int i = 0; i < 2; i++)
    begin
      if (!sleep_cond && scaling_select_pin[i])
      begin
        target[i] = scaled_setpoint_code[i]; // dvs pin high [R14]
      end
      unique case (step_interval_sel[i]) // [R18] [R16]
        2'h0: interval[i] = STEP_2US_CYC;
        2'h1: interval[i] = STEP_4US_CYC;
        2'h2: interval[i] = STEP_8US_CYC;
        2'h3: interval[i] = STEP_16US_CYC;
      endcase
    end
  end

  // one stepper per buck; code is range-relative [R7] [R8] [R13]
  generate
    for (genvar g = 0; g < NUM_BUCKS; g++)
    begin : g_buck
      assign sif[g].target = target[g];
      assign sif[g].interval = interval[g];
      assign code_q[g] = sif[g].code;
      assign busy_q[g] = sif[g].busy;
      bsc_stepper u_step (
        .mclk(mclk),
        .reset(reset),
        .sif(sif[g])
      );
    end
  endgenerate

  assign pll_force_on = force_reg;
  assign pll_mult_sel = mult_sel_reg;
  assign pll_mult_factor = factor_reg;
  assign pll_run = run_reg;
  assign pll_clk_ok = ok_reg;
  assign range_high_sel = range_reg;
  assign applied_code = code_q;
  assign step_busy = busy_q;

  // check helper: cycles since pll run rose, saturating
  // a counter keeps the start-up bound cheap for the property tools
  logic [6:0] run_age_reg, run_age_next; // cycles pll has been running

  // helper next-state: cleared while stopped, counts while running
  always_comb
  begin
    run_age_next = 7'h00; // pll stopped
    if (run_reg)
    begin
      // hold at the top, no wrap back to zero
      run_age_next = (run_age_reg == 7'h7f) ? run_age_reg : run_age_reg + 7'h01;
    end
  end

  // helper register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      run_age_reg <= 7'h00;
    end
    else
    begin
      run_age_reg <= run_age_next;
    end
  end

  // checks
  a_pll_auto_off: assert property (@(posedge mclk) disable iff (reset) // [R3]
    (!force_next && !(|(buck_on & ~buck_pfm)) && !pll_needed_ext) |=> !run_reg)
    else $error("pll kept on with no user");
  a_force_keeps_on: assert property (@(posedge mclk) disable iff (reset) // [R5]
    force_reg |-> run_reg)
    else $error("forced pll not running");
  a_mult_factor: assert property (@(posedge mclk) disable iff (reset) // [R2]
    factor_reg == 7'(7'd84 + 7'd3 * mult_sel_reg))
    else $error("multiplier factor wrong");
  a_clk_ok_bound: assert property (@(posedge mclk) disable iff (reset) // [R4]
    (run_reg && run_age_reg >= PLL_COLD_CYC) |-> ok_reg)
    else $error("pll clock late");
  a_clk_ok_early: assert property (@(posedge mclk) disable iff (reset) // [R4]
    ok_reg |-> (run_reg && run_age_reg >= PLL_WARM_CYC))
    else $error("pll clock ready too soon");
  a_run_on_user: assert property (@(posedge mclk) disable iff (reset) // [R4]
    (|(buck_on & ~buck_pfm)) |=> run_reg)
    else $error("pll not started for active buck");
  a_clk_drop: assert property (@(posedge mclk) disable iff (reset) // [R3]
    !run_reg |-> !ok_reg)
    else $error("clock ready with pll stopped");
  a_sel_sleep: assert property (@(posedge mclk) disable iff (reset) // [R15]
    (sleep_request_primary && sleep_request_secondary) |->
      (target[0] == sleep_setpoint_code[0] && target[1] == sleep_setpoint_code[1]))
    else $error("sleep set point not selected");
  a_sel_dvs: assert property (@(posedge mclk) disable iff (reset) // [R14]
    (!sleep_cond) |-> (target[0] == (scaling_select_pin[0] ?
      scaled_setpoint_code[0] : normal_setpoint_code[0])))
    else $error("dvs pin selection wrong");
  a_range_strap: assert property (@(posedge mclk) disable iff (reset) // [R10]
    $fell(init_reg) |-> (range_reg[0] == 1'b0 && range_reg[3] == 1'b1
      && range_reg[1] == $past(powerup_strap2_grounded)
      && range_reg[2] == $past(powerup_strap2_grounded)))
    else $error("startup range bits wrong");
  a_range_write: assert property (@(posedge mclk) disable iff (reset) // [R11]
    (!init_reg && range_wr[1]) |=> (range_reg[1] == $past(range_wdata[1])))
    else $error("range bit write lost");
  a_range_hold: assert property (@(posedge mclk) disable iff (reset) // [R11]
    (!init_reg && !range_wr[0]) |=> $stable(range_reg[0]))
    else $error("range bit moved without write");
  a_fixed_rate: assert property (@(posedge mclk) disable iff (reset) // [R19]
    interval[2] == 11'd400 && interval[3] == 11'd400)
    else $error("fixed step rate wrong");
  a_rate_slowest: assert property (@(posedge mclk) disable iff (reset) // [R18]
    (step_interval_sel[0] == 2'h3) |-> (interval[0] == 11'd1600))
    else $error("slowest step rate wrong");
  a_sel_dvs_two: assert property (@(posedge mclk) disable iff (reset) // [R14]
    (!sleep_cond) |-> (target[1] == (scaling_select_pin[1] ?
      scaled_setpoint_code[1] : normal_setpoint_code[1])))
    else $error("dvs pin selection wrong on buck two");
  a_sel_sleep_fixed: assert property (@(posedge mclk) disable iff (reset) // [R15]
    sleep_cond |->
      (target[2] == sleep_setpoint_code[2] && target[3] == sleep_setpoint_code[3]))
    else $error("sleep set point not selected on fixed-rate bucks");
  c_pll_cold: cover property (@(posedge mclk) disable iff (reset) $rose(ok_reg));
  c_sleep_step: cover property (@(posedge mclk) disable iff (reset)
    sleep_cond && busy_q[0]);
  c_dvs_step: cover property (@(posedge mclk) disable iff (reset)
    scaling_select_pin[1] && busy_q[1]);
endmodule // bsc_ctrl

// >>> verif/bsc_ap_model.sv
/*
  processor-side model: drives the dvs pins and both sleep pins.
  assumes commands from the bench arrive at the rising edge of mclk.
*/
`timescale 1ns/1ps
module bsc_ap_model
(
  input wire logic mclk,
  input wire logic [1:0] want_dvs,
  input wire logic want_sleep,
  output logic [1:0] dvs_pin,
  output logic sleep_pri,
  output logic sleep_sec
);
  // pins follow commands one cycle later
  always_ff @(posedge mclk)
  begin
    dvs_pin <= want_dvs;
    // both pins raised together, sleep is their and
    sleep_pri <= want_sleep;
    sleep_sec <= want_sleep;
  end
endmodule // bsc_ap_model

// >>> verif/bsc_ctrl_bench.sv
/*
  self-checking bench for the set-point and pll controller.
  assumes a 100 mhz mclk and the processor model beside the design.
*/
`timescale 1ns/1ps
module bsc_ctrl_bench;
  import bsc_pkg::*;
  logic mclk = 0, reset = 1, grn = 1, pwr = 0, pfo = 0, strap = 0, ext = 0;
  logic [2:0] pms = 0;
  logic [3:0] rwr = 0, rwd = 0, bon = 0, bpfm = 0;
  logic [3:0][4:0] nrm = 0, slp = 0;
  logic [1:0][4:0] scl = 0;
  logic [1:0][1:0] ssel = 0;
  logic [1:0] wdvs = 0, dvs;
  logic wslp = 0, sp, ss, force_q, run, ok;
  logic [2:0] msel;
  logic [6:0] fac;
  logic [3:0] rng, busy;
  logic [3:0][4:0] code;
  int errors = 0, checks_done = 0, cyc = 0, cnt, iv;
  bsc_ap_model u_ap (.mclk(mclk), .want_dvs(wdvs), .want_sleep(wslp),
    .dvs_pin(dvs), .sleep_pri(sp), .sleep_sec(ss));
  bsc_ctrl u_dut (.mclk(mclk), .reset(reset), .global_rst_n(grn), .pll_wr(pwr),
    .pll_force_on_wdata(pfo), .pll_mult_sel_wdata(pms), .range_wr(rwr),
    .range_wdata(rwd), .powerup_strap2_grounded(strap), .normal_setpoint_code(nrm),
    .scaled_setpoint_code(scl), .sleep_setpoint_code(slp), .step_interval_sel(ssel),
    .scaling_select_pin(dvs), .sleep_request_primary(sp), .sleep_request_secondary(ss),
    .buck_on(bon), .buck_pfm(bpfm), .pll_needed_ext(ext), .pll_force_on(force_q),
    .pll_mult_sel(msel), .pll_mult_factor(fac), .pll_run(run), .pll_clk_ok(ok),
    .range_high_sel(rng), .applied_code(code), .step_busy(busy));
  // free-running clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      wrap_up();
    end
  end
  // wait n edges, then sample settled
  task tk(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task rst(logic g);
    @(posedge mclk);
    reset <= 1;
    strap <= g;
    tk(5);
    @(posedge mclk);
    reset <= 0;
    tk(3);
  endtask
  // one pll field write
  task pw(logic f, logic [2:0] m);
    @(posedge mclk);
    pwr <= 1;
    pfo <= f;
    pms <= m;
    @(posedge mclk);
    pwr <= 0;
    #1;
  endtask
  // cycles until clock ready, bounded
  task wok(int lim);
    cnt = 0;
    while (ok !== 1'b1 && cnt < 200)
    begin
      tk(1);
      cnt++;
    end
    chk(cnt <= lim, 1);
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    rst(0);
    chk(force_q, 0);
    chk(msel, 4);
    chk(fac, 96);
    chk(run, 0);
    chk(rng, 4'h8);
    for (int i = 0; i < 8; i++)
    begin
      pw(0, i[2:0]);
      chk(fac, 84 + 3 * i);
    end
    $display("multiplier test done");
    pw(1, 4);
    wok(73);
    chk(run, 1);
    @(posedge mclk);
    grn <= 0;
    @(posedge mclk);
    grn <= 1;
    tk(3);
    chk(force_q, 0);
    chk({run, ok}, 0);
    @(posedge mclk);
    bon <= 4'h8;
    wok(72);
    @(posedge mclk);
    bpfm <= 4'h8;
    tk(3);
    chk(run, 0);
    @(posedge mclk);
    ext <= 1;
    tk(3);
    chk(run, 1);
    @(posedge mclk);
    ext <= 0;
    tk(3);
    @(posedge mclk);
    bpfm <= 0;
    wok(62);
    @(posedge mclk);
    bon <= 0;
    $display("pll test done");
    @(posedge mclk);
    nrm[1] <= 2;
    tk(190);
    chk(code[1], 0);
    tk(20);
    chk(code[1], 1);
    tk(200);
    chk({busy[1], code[1]}, 2);
    @(posedge mclk);
    scl[1] <= 4;
    wdvs <= 2'h2;
    tk(215);
    chk(code[1], 3);
    tk(200);
    chk(code[1], 4);
    @(posedge mclk);
    slp[1] <= 3;
    wslp <= 1;
    tk(215);
    chk(code[1], 3);
    @(posedge mclk);
    wdvs <= 0;
    tk(400);
    chk(code[1], 3);
    @(posedge mclk);
    wslp <= 0;
    tk(215);
    chk(code[1], 2);
    $display("selection test done");
    @(posedge mclk);
    nrm[2] <= 1;
    tk(360);
    chk(code[2], 0);
    tk(80);
    chk(code[2], 1);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge mclk);
      ssel[0] <= s[1:0];
      tk(1700);
      @(posedge mclk);
      nrm[0] <= 5'(s + 1);
      iv = 200 << s;
      tk(iv * 9 / 10);
      chk(code[0], s);
      tk(iv / 5);
      chk(code[0], s + 1);
    end
    $display("stepping test done");
    @(posedge mclk);
    rwr <= 4'hf;
    rwd <= 4'h6; // buck one bit kept clear, one deliberate write
    @(posedge mclk);
    rwr <= 0;
    tk(1);
    chk(rng, 4'h6);
    chk(code[1], 2);
    rst(1);
    chk(rng, 4'he);
    $display("range test done");
    wrap_up();
  end
endmodule // bsc_ctrl_bench
